// ==== shared/sctsr_regs.svh ====
// constants of the transport status page responder
// assumes inclusion by bare name from design and bench files
`ifndef SCTSR_REGS_SVH
`define SCTSR_REGS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define SCTSR_OFS_CTRL    8'h00
`define SCTSR_OFS_CODES   8'h04
`define SCTSR_OFS_EXTSTAT 8'h08
`define SCTSR_OFS_LBA_LO  8'h0c
`define SCTSR_OFS_LBA_HI  8'h10
`define SCTSR_OFS_TEMPS   8'h14
`define SCTSR_OFS_LIFEMAX 8'h18
`define SCTSR_OFS_FLAGS   8'h1c

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define SCTSR_CTRL_BUSY_BIT 8
`define SCTSR_FLAG_SEG_BIT  0
`define SCTSR_FLAG_STRM_BIT 1
`define SCTSR_TEMP_INVALID  8'h80
`define SCTSR_DRV_IDLE      8'h00

// ----------------------------------------
// page contents and layout
// ----------------------------------------
`define SCTSR_FMT_VER     16'h0003
`define SCTSR_SPEC_VER    16'h0001
`define SCTSR_BUSY_STATUS 16'hffff
`define SCTSR_PAGE_LAST   9'h1ff
`define SCTSR_B_FMT0      9'h000
`define SCTSR_B_FMT1      9'h001
`define SCTSR_B_IMP0      9'h002
`define SCTSR_B_IMP1      9'h003
`define SCTSR_B_SPEC0     9'h004
`define SCTSR_B_SPEC1     9'h005
`define SCTSR_B_FLAGS     9'h006
`define SCTSR_B_DRIVE     9'h00a
`define SCTSR_B_EXT0      9'h00e
`define SCTSR_B_EXT1      9'h00f
`define SCTSR_B_ACT0      9'h010
`define SCTSR_B_ACT1      9'h011
`define SCTSR_B_FUN0      9'h012
`define SCTSR_B_FUN1      9'h013
`define SCTSR_B_LBA0      9'h028
`define SCTSR_B_LBA7      9'h02f
`define SCTSR_B_TCUR      9'h0c8
`define SCTSR_B_TMIN      9'h0c9
`define SCTSR_B_TMAX      9'h0ca
`define SCTSR_B_TLMIN     9'h0cb
`define SCTSR_B_TLMAX     9'h0cc

// ----------------------------------------
// taskfile codes
// ----------------------------------------
`define SCTSR_CMD_SMART   8'hb0
`define SCTSR_FEAT_SMART  8'hd5
`define SCTSR_SIG_LOW     8'h4f
`define SCTSR_SIG_HIGH    8'hc2
`define SCTSR_CMD_LOGEXT  8'h2f
`define SCTSR_LOG_STATUS  8'he0
`define SCTSR_ONE_SECTOR  8'h01
`define SCTSR_ZERO_BYTE   8'h00

`endif

// ==== shared/sctsr_pkg.sv ====
// types of the transport status page responder
// assumes the constants header sits beside it
package sctsr_pkg;
	// page streamer states
	typedef enum logic {
		SCTSR_IDLE,
		SCTSR_STREAM
	} sctsr_state_t;
endpackage : sctsr_pkg

// ==== logic/sctsr_page_byte.sv ====
// byte selector of the status page, registered output
// assumes fields stay steady for one cycle around each index
`timescale 1ns/1ps
`default_nettype none
`include "sctsr_regs.svh"

module sctsr_page_byte
	import sctsr_pkg::*;
#(
	parameter logic [15:0] IMPL_VERSION = 16'h0001 // arbitrary value
) (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// byte position and fields
	input  wire logic [8:0]  index,
	input  wire logic        seg_init,
	input  wire logic [7:0]  drive_state,
	input  wire logic [15:0] ext_status,
	input  wire logic [15:0] action_code,
	input  wire logic [15:0] function_code,
	input  wire logic [63:0] cur_lba,
	input  wire logic [39:0] temps,
	// selected byte
	output var  logic [7:0]  byte_r
);
	logic [7:0] byte_nxt;
	logic [2:0] lba_sel;

	// pick the byte; every unnamed position outside the lba qword reads zero
	always_comb begin
		lba_sel  = index[2:0];
		byte_nxt = 8'h00;
		unique case (index)
			`SCTSR_B_FMT0:  byte_nxt = 8'(`SCTSR_FMT_VER);
			`SCTSR_B_FMT1:  byte_nxt = 8'(`SCTSR_FMT_VER >> 8);
			`SCTSR_B_IMP0:  byte_nxt = IMPL_VERSION[7:0];
			`SCTSR_B_IMP1:  byte_nxt = IMPL_VERSION[15:8];
			`SCTSR_B_SPEC0: byte_nxt = 8'(`SCTSR_SPEC_VER);
			`SCTSR_B_SPEC1: byte_nxt = 8'(`SCTSR_SPEC_VER >> 8);
			`SCTSR_B_FLAGS: byte_nxt = {7'h00, seg_init};
			`SCTSR_B_DRIVE: byte_nxt = drive_state;
			`SCTSR_B_EXT0:  byte_nxt = ext_status[7:0];
			`SCTSR_B_EXT1:  byte_nxt = ext_status[15:8];
			`SCTSR_B_ACT0:  byte_nxt = action_code[7:0];
			`SCTSR_B_ACT1:  byte_nxt = action_code[15:8];
			`SCTSR_B_FUN0:  byte_nxt = function_code[7:0];
			`SCTSR_B_FUN1:  byte_nxt = function_code[15:8];
			`SCTSR_B_TCUR:  byte_nxt = temps[7:0];
			`SCTSR_B_TMIN:  byte_nxt = temps[15:8];
			`SCTSR_B_TMAX:  byte_nxt = temps[23:16];
			`SCTSR_B_TLMIN: byte_nxt = temps[31:24];
			`SCTSR_B_TLMAX: byte_nxt = temps[39:32];
			default: begin
				// lba bytes sit on one aligned qword
				if (index >= `SCTSR_B_LBA0 && index <= `SCTSR_B_LBA7) begin
					byte_nxt = cur_lba[lba_sel*8 +: 8];
				end
			end
		endcase
	end

	// output register
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			byte_r <= 8'h00;
		end else begin
			byte_r <= byte_nxt;
		end
	end
endmodule : sctsr_page_byte
`default_nettype wire

// ==== logic/sctsr_status_responder.sv ====
// transport status page responder: taskfile decode, fields, page stream
// assumes taskfile inputs are synchronous and valid with tf_cmd_valid
`timescale 1ns/1ps
`default_nettype none
`include "sctsr_regs.svh"

module sctsr_status_responder
	import sctsr_pkg::*;
#(
	parameter logic [15:0] IMPL_VERSION = 16'h0001 // arbitrary value
) (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output var  logic [31:0] reg_rdata,
	// taskfile
	input  wire logic        tf_cmd_valid,
	input  wire logic [7:0]  tf_command,
	input  wire logic [7:0]  tf_feature,
	input  wire logic [7:0]  tf_count,
	input  wire logic [7:0]  tf_count_prev,
	input  wire logic [7:0]  tf_lba_low,
	input  wire logic [7:0]  tf_lba_mid,
	input  wire logic [7:0]  tf_lba_mid_prev,
	input  wire logic [7:0]  tf_lba_high,
	// media events
	input  wire logic        ev_write_all_ok,
	input  wire logic        ev_user_write,
	input  wire logic        ev_capacity_change,
	// nonvolatile flag store
	input  wire logic        nv_seg_init,
	output var  logic        nv_seg_wr,
	output var  logic        nv_seg_data,
	// page stream
	output var  logic        req_taken,
	output var  logic        page_valid,
	output var  logic [8:0]  page_index,
	output var  logic        page_last,
	output var  logic [7:0]  page_byte
);
	// ----------------------------------------
	// software registers
	// ----------------------------------------
	logic [7:0]  drive_state_r, drive_state_nxt;
	logic        sct_busy_r, sct_busy_nxt;
	logic [15:0] action_r, action_nxt;
	logic [15:0] function_r, function_nxt;
	logic [15:0] ext_status_r, ext_status_nxt;
	logic [63:0] lba_r, lba_nxt;
	logic [31:0] temps_r, temps_nxt;
	logic [7:0]  life_max_r, life_max_nxt;
	logic [31:0] rdata_nxt;
	logic [15:0] ext_report;
	logic        seg_init_r, seg_init_nxt;
	logic        nv_loaded_r, nv_loaded_nxt;
	logic        nv_wr_nxt;
	logic        streaming;

	// busy overrides the stored completion status
	assign ext_report = sct_busy_r ? `SCTSR_BUSY_STATUS : ext_status_r;

	// register writes; a status request never touches these
	always_comb begin
		drive_state_nxt = drive_state_r;
		sct_busy_nxt    = sct_busy_r;
		action_nxt      = action_r;
		function_nxt    = function_r;
		ext_status_nxt  = ext_status_r;
		lba_nxt         = lba_r;
		temps_nxt       = temps_r;
		life_max_nxt    = life_max_r;
		if (reg_wr) begin
			unique case (reg_addr)
				`SCTSR_OFS_CTRL: begin
					drive_state_nxt = reg_wdata[7:0];
					sct_busy_nxt    = reg_wdata[`SCTSR_CTRL_BUSY_BIT];
				end
				`SCTSR_OFS_CODES: begin
					action_nxt   = reg_wdata[15:0];
					function_nxt = reg_wdata[31:16];
				end
				`SCTSR_OFS_EXTSTAT: ext_status_nxt = reg_wdata[15:0];
				`SCTSR_OFS_LBA_LO:  lba_nxt[31:0]  = reg_wdata;
				`SCTSR_OFS_LBA_HI:  lba_nxt[63:32] = reg_wdata;
				`SCTSR_OFS_TEMPS:   temps_nxt      = reg_wdata;
				`SCTSR_OFS_LIFEMAX: life_max_nxt   = reg_wdata[7:0];
				default: ;
			endcase
		end
	end

	// register read mux, data valid the cycle after the strobe
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (reg_rd) begin
			unique case (reg_addr)
				`SCTSR_OFS_CTRL:    rdata_nxt = {23'h0, sct_busy_r, drive_state_r};
				`SCTSR_OFS_CODES:   rdata_nxt = {function_r, action_r};
				`SCTSR_OFS_EXTSTAT: rdata_nxt = {16'h0, ext_report};
				`SCTSR_OFS_LBA_LO:  rdata_nxt = lba_r[31:0];
				`SCTSR_OFS_LBA_HI:  rdata_nxt = lba_r[63:32];
				`SCTSR_OFS_TEMPS:   rdata_nxt = temps_r;
				`SCTSR_OFS_LIFEMAX: rdata_nxt = {24'h0, life_max_r};
				`SCTSR_OFS_FLAGS:   rdata_nxt = {30'h0, streaming, seg_init_r};
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	// register file storage; temperatures start invalid
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			drive_state_r <= `SCTSR_DRV_IDLE;
			sct_busy_r    <= 1'b0;
			action_r      <= 16'h0000;
			function_r    <= 16'h0000;
			ext_status_r  <= 16'h0000;
			lba_r         <= 64'h0;
			temps_r       <= {4{`SCTSR_TEMP_INVALID}};
			life_max_r    <= `SCTSR_TEMP_INVALID;
			reg_rdata     <= 32'h0000_0000;
		end else begin
			drive_state_r <= drive_state_nxt;
			sct_busy_r    <= sct_busy_nxt;
			action_r      <= action_nxt;
			function_r    <= function_nxt;
			ext_status_r  <= ext_status_nxt;
			lba_r         <= lba_nxt;
			temps_r       <= temps_nxt;
			life_max_r    <= life_max_nxt;
			reg_rdata     <= rdata_nxt;
		end
	end

	// ----------------------------------------
	// segment initialised flag
	// ----------------------------------------
	// stored copy is fetched in the first cycle after reset release, since
	// an async reset may only load a constant
	always_comb begin
		nv_loaded_nxt = 1'b1;
		seg_init_nxt  = nv_loaded_r ? seg_init_r : nv_seg_init;
		if (ev_user_write || ev_capacity_change) begin
			seg_init_nxt = 1'b0;
		end
		// the full write-all itself writes lbas, so its completion wins
		if (ev_write_all_ok) begin
			seg_init_nxt = 1'b1;
		end
		nv_wr_nxt = nv_loaded_r && (seg_init_nxt != seg_init_r);
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			nv_loaded_r <= 1'b0;
			seg_init_r  <= 1'b0;
			nv_seg_wr   <= 1'b0;
			nv_seg_data <= 1'b0;
		end else begin
			nv_loaded_r <= nv_loaded_nxt;
			seg_init_r  <= seg_init_nxt;
			nv_seg_wr   <= nv_wr_nxt;
			nv_seg_data <= seg_init_nxt;
		end
	end

	// ----------------------------------------
	// request decode and page stream
	// ----------------------------------------
	sctsr_state_t state_r, state_nxt;
	logic [8:0]   cnt_r, cnt_nxt;
	logic         smart_hit, logext_hit, start;
	logic         taken_nxt;

	// both command forms select log e0
	assign smart_hit  = tf_command == `SCTSR_CMD_SMART && tf_feature == `SCTSR_FEAT_SMART
		&& tf_count == `SCTSR_ONE_SECTOR && tf_lba_low == `SCTSR_LOG_STATUS
		&& tf_lba_mid == `SCTSR_SIG_LOW && tf_lba_high == `SCTSR_SIG_HIGH;
	assign logext_hit = tf_command == `SCTSR_CMD_LOGEXT && tf_count == `SCTSR_ONE_SECTOR
		&& tf_count_prev == `SCTSR_ZERO_BYTE && tf_lba_low == `SCTSR_LOG_STATUS
		&& tf_lba_mid == `SCTSR_ZERO_BYTE
		&& tf_lba_mid_prev == `SCTSR_ZERO_BYTE;
	assign streaming  = state_r == SCTSR_STREAM;
	// a request during a running page is dropped, not queued
	assign start      = tf_cmd_valid && (smart_hit || logext_hit) && !streaming;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		taken_nxt = start;
		unique case (state_r)
			SCTSR_IDLE: begin
				if (start) begin
					state_nxt = SCTSR_STREAM;
					cnt_nxt   = 9'h000;
				end
			end
			SCTSR_STREAM: begin
				cnt_nxt = cnt_r + 9'h001;
				if (cnt_r == `SCTSR_PAGE_LAST) begin
					state_nxt = SCTSR_IDLE;
				end
			end
		endcase
	end

	// stream flags lag the counter by one to meet the registered byte
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_r    <= SCTSR_IDLE;
			cnt_r      <= 9'h000;
			req_taken  <= 1'b0;
			page_valid <= 1'b0;
			page_index <= 9'h000;
			page_last  <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			cnt_r      <= cnt_nxt;
			req_taken  <= taken_nxt;
			page_valid <= streaming;
			page_index <= cnt_r;
			page_last  <= streaming && cnt_r == `SCTSR_PAGE_LAST;
		end
	end

	// fields are live, so a byte reflects the value one cycle before it
	sctsr_page_byte #(
		.IMPL_VERSION (IMPL_VERSION)
	) u_byte (
		.clock         (clock),
		.rst_n         (rst_n),
		.index         (cnt_r),
		.seg_init      (seg_init_r),
		.drive_state   (drive_state_r),
		.ext_status    (ext_report),
		.action_code   (action_r),
		.function_code (function_r),
		.cur_lba       (lba_r),
		.temps         ({life_max_r, temps_r}),
		.byte_r        (page_byte)
	);

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	smart_decode_a: assert property (
		tf_cmd_valid && smart_hit && !streaming |=> req_taken ##1 page_valid && page_index == 9'h0)
		else $error("smart form not served");
	logext_decode_a: assert property (
		tf_cmd_valid && logext_hit && !streaming |=> ##1 page_valid && page_byte == 8'h03)
		else $error("log ext form not served");
	format_ver_a: assert property (
		page_valid && page_index == 9'h001 |-> page_byte == 8'h00)
		else $error("format version high byte wrong");
	spec_ver_a: assert property (
		page_valid && page_index == 9'h004 |-> page_byte == 8'h01)
		else $error("spec level wrong");
	seg_set_a: assert property (
		nv_loaded_r && ev_write_all_ok |=> seg_init_r)
		else $error("segment flag not set");
	seg_clear_a: assert property (
		nv_loaded_r && (ev_user_write || ev_capacity_change) && !ev_write_all_ok |=> !seg_init_r)
		else $error("segment flag not cleared");
	nv_store_a: assert property (
		nv_loaded_r && (ev_write_all_ok ? !seg_init_r
			: (ev_user_write || ev_capacity_change) && seg_init_r)
		|=> nv_seg_wr && nv_seg_data == seg_init_r)
		else $error("flag change not stored");
	busy_status_a: assert property (
		page_valid && page_index == 9'h00e && $past(sct_busy_r) |-> page_byte == 8'hff)
		else $error("busy status not ffffh");
	temp_cur_a: assert property (
		page_valid && page_index == 9'h0c8 |-> page_byte == $past(temps_r[7:0]))
		else $error("current temperature byte wrong");
	reserved_zero_a: assert property (
		page_valid && page_index >= 9'h030 && page_index < 9'h0c8 |-> page_byte == 8'h00)
		else $error("reserved byte not zero");
	state_kept_a: assert property (
		start && !reg_wr |=> $stable(drive_state_r) && $stable(sct_busy_r))
		else $error("request altered drive state");
	page_end_a: assert property (
		page_last |-> page_index == 9'h1ff ##1 !page_valid)
		else $error("page length wrong");
	impl_ver_a: assert property (
		page_valid && page_index == 9'h002 |-> page_byte == IMPL_VERSION[7:0])
		else $error("implementation version low byte wrong");
	cap_clear_a: assert property (
		nv_loaded_r && ev_capacity_change && !ev_write_all_ok |=> !seg_init_r)
		else $error("capacity change kept segment flag");
	drive_state_a: assert property (
		page_valid && page_index == 9'h00a |-> page_byte == $past(drive_state_r))
		else $error("drive state byte wrong");
	last_status_a: assert property (
		page_valid && page_index == 9'h00f && !$past(sct_busy_r)
		|-> page_byte == $past(ext_status_r[15:8]))
		else $error("completion status byte wrong");
	action_code_a: assert property (
		page_valid && page_index == 9'h010 |-> page_byte == $past(action_r[7:0]))
		else $error("action code byte wrong");
	function_code_a: assert property (
		page_valid && page_index == 9'h013 |-> page_byte == $past(function_r[15:8]))
		else $error("function code byte wrong");
	lba_byte_a: assert property (
		page_valid && page_index == 9'h028 |-> page_byte == $past(lba_r[7:0]))
		else $error("lba low byte wrong");
	life_max_a: assert property (
		page_valid && page_index == 9'h0cc |-> page_byte == $past(life_max_r))
		else $error("lifetime maximum byte wrong");
	low_reserved_a: assert property (
		page_valid && (page_index inside {[9'h00b:9'h00d], [9'h014:9'h027]})
		|-> page_byte == 8'h00)
		else $error("low reserved byte not zero");

	smart_req_c: cover property (tf_cmd_valid && smart_hit && !streaming);
	logext_req_c: cover property (tf_cmd_valid && logext_hit && !streaming);
	busy_page_c: cover property (page_valid && page_index == 9'h00e && page_byte == 8'hff);
	seg_cycle_c: cover property (seg_init_r ##1 !seg_init_r);
endmodule : sctsr_status_responder
`default_nettype wire

// ==== verification/sctsr_host_model.sv ====
// host side model: issues taskfile commands and collects the status page
// assumes it shares one clock with the responder and reads every page byte
`timescale 1ns/1ps
`default_nettype none

module sctsr_host_model (
	// clock
	input  wire logic        clock,
	// taskfile
	output var  logic        tf_cmd_valid,
	output var  logic [7:0]  tf_command,
	output var  logic [7:0]  tf_feature,
	output var  logic [7:0]  tf_count,
	output var  logic [7:0]  tf_count_prev,
	output var  logic [7:0]  tf_lba_low,
	output var  logic [7:0]  tf_lba_mid,
	output var  logic [7:0]  tf_lba_mid_prev,
	output var  logic [7:0]  tf_lba_high,
	// page stream
	input  wire logic        page_valid,
	input  wire logic [8:0]  page_index,
	input  wire logic        page_last,
	input  wire logic [7:0]  page_byte
);
	logic [63:0] tf_r = 64'h0;
	logic [7:0]  page_mem [512];
	int          pages = 0;

	// packed as command, feature, count, count prev, low, mid, mid prev, high
	assign {tf_command, tf_feature, tf_count, tf_count_prev,
		tf_lba_low, tf_lba_mid, tf_lba_mid_prev, tf_lba_high} = tf_r;

	initial begin
		tf_cmd_valid = 1'b0;
	end

	// bytes stand for the one valid cycle, then flip so stale values never match
	task automatic issue(input logic [63:0] tf);
		@(posedge clock);
		tf_r         <= tf;
		tf_cmd_valid <= 1'b1;
		@(posedge clock);
		tf_r         <= ~tf;
		tf_cmd_valid <= 1'b0;
	endtask : issue

	// page capture, placed by the stream's own index
	always @(posedge clock) begin
		if (page_valid)
			page_mem[page_index] <= page_byte;
		if (page_valid && page_last)
			pages <= pages + 1;
	end
endmodule : sctsr_host_model
`default_nettype wire

// ==== verification/test_sct_status_page_responder.sv ====
// self-checking bench of the transport status page responder
// assumes the responder, its constants header and the host model compile first
`timescale 1ns/1ps
`default_nettype none
`include "sctsr_regs.svh"

module test_sct_status_page_responder;
	localparam logic [15:0] IMPL_VER   = 16'h5a3c; // arbitrary value
	localparam logic [63:0] SMART_REQ  = 64'hb0_d5_01_00_e0_4f_00_c2;
	localparam logic [63:0] LOGEXT_REQ = 64'h2f_7e_01_00_e0_00_00_5b;
	localparam logic [7:0]  SMART_MASK = 8'b1110_1101;
	localparam logic [7:0]  LOG_MASK   = 8'b1011_1110;

	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic        tf_cmd_valid;
	logic [7:0]  tf_command, tf_feature, tf_count, tf_count_prev;
	logic [7:0]  tf_lba_low, tf_lba_mid, tf_lba_mid_prev, tf_lba_high;
	logic [2:0]  ev = 3'b000;
	logic        nv_seg_init = 1'b1;
	logic        nv_seg_wr, nv_seg_data, req_taken, page_valid, page_last;
	logic [8:0]  page_index;
	logic [7:0]  page_byte;
	// expected field values, as firmware last wrote them
	logic [7:0]  drv = 8'h00;
	logic        busy = 1'b0;
	logic        seg = 1'b1;
	logic [15:0] ext = 16'h0, act = 16'h0, fun = 16'h0;
	logic [63:0] lba = 64'h0;
	logic [39:0] tmp = 40'h80_8080_8080;
	int          mismatches = 0;
	int          total_checks = 0;

	always #2.5 clock = ~clock;

	sctsr_status_responder #(
		.IMPL_VERSION(IMPL_VER)
	) u_sctsr_status_responder (
		.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.tf_cmd_valid, .tf_command, .tf_feature, .tf_count, .tf_count_prev,
		.tf_lba_low, .tf_lba_mid, .tf_lba_mid_prev, .tf_lba_high,
		.ev_write_all_ok(ev[0]), .ev_user_write(ev[1]), .ev_capacity_change(ev[2]),
		.nv_seg_init, .nv_seg_wr, .nv_seg_data,
		.req_taken, .page_valid, .page_index, .page_last, .page_byte
	);

	sctsr_host_model u_sctsr_host_model (
		.clock, .tf_cmd_valid, .tf_command, .tf_feature, .tf_count, .tf_count_prev,
		.tf_lba_low, .tf_lba_mid, .tf_lba_mid_prev, .tf_lba_high,
		.page_valid, .page_index, .page_last, .page_byte
	);

	// ----------------------------------------
	// checking and bus tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : test_done

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clock);
		reg_wr    <= 1'b0;
	endtask : reg_write

	// read data stand only in the cycle after the strobe
	task automatic read_check(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clock);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clock);
		reg_rd   <= 1'b0;
		#1;
		check($sformatf("reg %h", a), exp, reg_rdata);
	endtask : read_check

	task automatic set_fields();
		reg_write(`SCTSR_OFS_CTRL, {23'h0, busy, drv});
		reg_write(`SCTSR_OFS_CODES, {fun, act});
		reg_write(`SCTSR_OFS_EXTSTAT, {16'h0, ext});
		reg_write(`SCTSR_OFS_LBA_LO, lba[31:0]);
		reg_write(`SCTSR_OFS_LBA_HI, lba[63:32]);
		reg_write(`SCTSR_OFS_TEMPS, tmp[31:0]);
		reg_write(`SCTSR_OFS_LIFEMAX, {24'h0, tmp[39:32]});
	endtask : set_fields

	// ----------------------------------------
	// page expectation and request tasks
	// ----------------------------------------
	function automatic logic [7:0] exp_byte(input int i);
		logic [15:0] es;
		es = busy ? 16'hffff : ext;
		if (i >= 40 && i <= 47)
			return lba[8 * (i - 40) +: 8];
		if (i >= 200 && i <= 204)
			return tmp[8 * (i - 200) +: 8];
		case (i)
			0: return 8'h03;
			2: return IMPL_VER[7:0];
			3: return IMPL_VER[15:8];
			4: return 8'h01;
			6: return {7'h0, seg};
			10: return drv;
			14: return es[7:0];
			15: return es[15:8];
			16: return act[7:0];
			17: return act[15:8];
			18: return fun[7:0];
			19: return fun[15:8];
			default: return 8'h00;
		endcase
	endfunction : exp_byte

	task automatic wait_page(output int n);
		int p0;
		p0 = u_sctsr_host_model.pages;
		n = 0;
		while (u_sctsr_host_model.pages == p0) begin
			@(posedge clock);
			#1;
			n++;
			if (n > 600) begin
				check("page wait", 0, 1);
				test_done();
			end
		end
	endtask : wait_page

	// lba bytes are only defined while a command runs in background
	task automatic get_page(input logic [63:0] tf, input string name);
		int n;
		u_sctsr_host_model.issue(tf);
		#1;
		check("req_taken", 1, req_taken);
		wait_page(n);
		check("page length", 513, n);
		for (int i = 0; i < 512; i++)
			if (busy || i < 40 || i > 47)
				check($sformatf("page byte %0d", i), exp_byte(i), u_sctsr_host_model.page_mem[i]);
		read_check(`SCTSR_OFS_CTRL, {23'h0, busy, drv});
		$display("test %s done", name);
	endtask : get_page

	task automatic refuse(input logic [63:0] tf);
		int n;
		n = 0;
		u_sctsr_host_model.issue(tf);
		repeat (3) begin
			#1;
			if (req_taken !== 1'b0)
				n++;
			@(posedge clock);
		end
		check("refused request", 0, n);
	endtask : refuse

	// the store is written only when the flag really changes
	task automatic flag_event(input logic [2:0] evs, input logic nseg);
		int   w;
		logic d;
		w = 0;
		d = 1'b0;
		@(posedge clock);
		ev <= evs;
		@(posedge clock);
		ev <= 3'b000;
		repeat (3) begin
			#1;
			if (nv_seg_wr === 1'b1) begin
				w++;
				d = nv_seg_data;
			end
			@(posedge clock);
		end
		check("store writes", (nseg != seg) ? 1 : 0, w);
		if (w > 0)
			check("store data", {31'h0, nseg}, {31'h0, d});
		seg = nseg;
		read_check(`SCTSR_OFS_FLAGS, {31'h0, seg});
	endtask : flag_event

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		int n;
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		read_check(`SCTSR_OFS_TEMPS, 32'h8080_8080);
		read_check(`SCTSR_OFS_LIFEMAX, 32'h80);
		read_check(`SCTSR_OFS_FLAGS, 32'h1);
		read_check(8'h40, 32'h0);
		reg_write(`SCTSR_OFS_FLAGS, 32'h0);
		read_check(`SCTSR_OFS_FLAGS, 32'h1);
		get_page(SMART_REQ, "reset page");
		busy = 1'b1;
		drv = 8'h05;
		ext = 16'h0008;
		act = 16'h0002;
		fun = 16'h0101;
		lba = 64'h0123_4567_89ab_cdef;
		tmp = 40'h46_f637_142d;
		set_fields();
		get_page(LOGEXT_REQ, "background page");
		// a second request while a page streams is dropped
		u_sctsr_host_model.issue(SMART_REQ);
		repeat (20) @(posedge clock);
		refuse(LOGEXT_REQ);
		wait_page(n);
		repeat (3) @(posedge clock);
		#1;
		check("no second page", 0, page_valid);
		$display("test busy request done");
		busy = 1'b0;
		for (int s = 0; s < 5; s++) begin
			drv = s[7:0];
			set_fields();
			get_page(s[0] ? LOGEXT_REQ : SMART_REQ, "drive state");
		end
		for (int k = 0; k < 8; k++) begin
			if (SMART_MASK[k])
				refuse(SMART_REQ ^ (64'h1 << (8 * k)));
			if (LOG_MASK[k])
				refuse(LOGEXT_REQ ^ (64'h1 << (8 * k)));
		end
		$display("test near forms done");
		flag_event(3'b010, 1'b0);
		flag_event(3'b100, 1'b0);
		flag_event(3'b001, 1'b1);
		flag_event(3'b100, 1'b0);
		flag_event(3'b001, 1'b1);
		flag_event(3'b010, 1'b0);
		// completion beside a user write: the set wins
		flag_event(3'b011, 1'b1);
		get_page(SMART_REQ, "flag events");
		test_done();
	end
endmodule : test_sct_status_page_responder
`default_nettype wire
